// ---- shared/rcf_consts.vh ----
/*
 * Constants of the reset-cause flag block: register offsets, flag bit
 * positions, reset values and control command bits.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef RCF_CONSTS_VH
`define RCF_CONSTS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define RCF_OFS_STATUS 4'h0
`define RCF_OFS_PWRCTL 4'h4
`define RCF_OFS_CTRL 4'h8
`define RCF_OFS_STACK 4'hC

// ************************************************************
// status register fields
// ************************************************************
`define RCF_ST_TIMEOUT 1
`define RCF_ST_POWERDOWN 0

// ************************************************************
// power-control register fields
// ************************************************************
`define RCF_PC_OVERFLOW 7
`define RCF_PC_UNDERFLOW 6
`define RCF_PC_WDT 4
`define RCF_PC_PIN 3
`define RCF_PC_INSTR 2
`define RCF_PC_POWERON 1
`define RCF_PC_BROWNOUT 0

// ************************************************************
// control register command bits (write one to act)
// ************************************************************
`define RCF_CT_RESET_INSTR 0
`define RCF_CT_SLEEP 1
`define RCF_CT_WDT_CLEAR 2

// ************************************************************
// reset values after power-on
// ************************************************************
`define RCF_RST_STATUS 2'h3
`define RCF_RST_PWRCTL 8'h1C

// ************************************************************
// stack
// ************************************************************
`define RCF_STACK_LEVELS 5'h10

`endif

// ---- hw/rcf_stack_guard.v ----
/*
 * Hardware return-stack depth tracker. Flags a push beyond the top
 * level or a pop beyond the first level.
 * Assumes push and pop come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rcf_consts.vh"

module rcf_stack_guard
(
  // clock and reset
  input wire clk,
  input wire rst,
  // core reset clears the stack
  input wire clear,
  // stack operations
  input wire push,
  input wire pop,
  // results
  output reg overflow,
  output reg underflow,
  output reg [4:0] depth
);

  // ************************************************************
  // depth counter
  // ************************************************************
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      depth <= 5'h00;
      overflow <= 1'b0;
      underflow <= 1'b0;
    end
    else
    begin
      overflow <= 1'b0;
      underflow <= 1'b0;
      if (clear)
        depth <= 5'h00;
      else if (push && !pop)
      begin
        if (depth == `RCF_STACK_LEVELS)
          overflow <= 1'b1;
        else
          depth <= depth + 5'h01;
      end
      else if (pop && !push)
      begin
        if (depth == 5'h00)
          underflow <= 1'b1;
        else
          depth <= depth - 5'h01;
      end
    end
  end

endmodule // rcf_stack_guard
`default_nettype wire

// ---- hw/rcf_top.v ----
/*
 * Reset-cause flag logic: sticky flags that tell firmware which reset
 * or wake event happened last, a stack-error reset source and a
 * classic Wishbone slave for the flag registers.
 * Assumes RST is the power-on reset; pin inputs are asynchronous.
 */
// Chosen here: the register addresses and the Wishbone register port.
// What this block does
// - with the stack-error fuse set, a push past level sixteen or a pop past level one resets the core.
// - every reset updates flags in the status or power-control registers to show its cause.
// - a stack-overflow reset sets the overflow flag and leaves all other cause flags alone.
// - a stack-underflow reset sets the underflow flag and leaves all other cause flags alone.
// - power-on sets time-out, power-down, watchdog, pin and instruction flags, clears power-on and stack flags.
// - a watchdog wake from sleep clears the time-out and power-down flags and keeps the rest.
// - an interrupt wake from sleep leaves time-out at one and power-down at zero, the rest kept.
// - the reset pin in normal operation clears the pin flag and keeps the rest.
// - the reset pin during sleep clears the pin flag, time-out to one, power-down to zero.
// - unchanged flags keep their value and an unknown flag takes an arbitrary fixed value.
`timescale 1ns/100ps
`default_nettype none
`include "rcf_consts.vh"

module rcf_top
(
  // clock and power-on reset
  input wire CLK,
  input wire RST,
  // wishbone slave
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [3:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O,
  // asynchronous pins
  input wire EXTERNAL_RESET_PIN_N,
  input wire BROWNOUT_DETECT,
  input wire STACK_ERROR_RESET_FUSE,
  // core events on this clock
  input wire WATCHDOG_TIMEOUT,
  input wire WAKE_INTERRUPT,
  input wire STACK_PUSH,
  input wire STACK_POP,
  // outputs to the core
  output reg CORE_RESET,
  output reg ASLEEP
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  reg [2:0] sync_a;
  reg [2:0] sync_b;
  reg pin_prev;
  reg brownout_prev;
  wire pin_n_s = sync_b[0];
  wire brownout_s = sync_b[1];
  wire fuse_s = sync_b[2];
  wire pin_evt = pin_prev && !pin_n_s;
  wire brownout_evt = brownout_s && !brownout_prev;

  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sync_a <= 3'h5;
      sync_b <= 3'h5;
      pin_prev <= 1'b1;
      brownout_prev <= 1'b0;
    end
    else
    begin
      sync_a <= {STACK_ERROR_RESET_FUSE, BROWNOUT_DETECT,
                 EXTERNAL_RESET_PIN_N};
      sync_b <= sync_a;
      pin_prev <= pin_n_s;
      brownout_prev <= brownout_s;
    end
  end

  // ************************************************************
  // stack guard
  // ************************************************************
  wire stk_ovf, stk_unf;
  wire [4:0] stk_depth;

  rcf_stack_guard i_rcf_stack_guard
  (
    .clk(CLK), .rst(RST), .clear(CORE_RESET),
    .push(STACK_PUSH), .pop(STACK_POP),
    .overflow(stk_ovf), .underflow(stk_unf), .depth(stk_depth)
  );

  wire ovf_evt = stk_ovf && fuse_s;
  wire unf_evt = stk_unf && fuse_s;

  // ************************************************************
  // wishbone decode
  // ************************************************************
  wire wb_req = CYC_I && STB_I;
  wire wb_wr = wb_req && WE_I && ACK_O && SEL_I[0];
  wire wr_status = wb_wr && (ADR_I == `RCF_OFS_STATUS);
  wire wr_pwrctl = wb_wr && (ADR_I == `RCF_OFS_PWRCTL);
  wire wr_ctrl = wb_wr && (ADR_I == `RCF_OFS_CTRL);
  wire cmd_instr = wr_ctrl && DAT_I[`RCF_CT_RESET_INSTR];
  wire cmd_sleep = wr_ctrl && DAT_I[`RCF_CT_SLEEP];
  wire cmd_wdtclr = wr_ctrl && DAT_I[`RCF_CT_WDT_CLEAR];

  // ************************************************************
  // flag registers
  // ************************************************************
  reg timeout_flag_n, powerdown_flag_n;
  reg stack_overflow_flag, stack_underflow_flag, watchdog_reset_flag_n;
  reg pin_reset_flag_n, instruction_reset_flag_n, poweron_flag_n;
  reg brownout_flag_n;
  reg next_timeout, next_powerdown, next_overflow, next_underflow;
  reg next_watchdog, next_pin, next_instr, next_poweron, next_brownout;
  reg next_asleep, next_reset;
  localparam [1:0] status_init = `RCF_RST_STATUS;
  localparam [7:0] pwrctl_init = `RCF_RST_PWRCTL;

  wire [7:0] pwrctl_rd = {stack_overflow_flag, stack_underflow_flag, 1'b0,
                          watchdog_reset_flag_n, pin_reset_flag_n,
                          instruction_reset_flag_n, poweron_flag_n,
                          brownout_flag_n};

  // register writes, watchdog clear and sleep first, then wake and reset events in rising strength
  always @*
  begin
    next_timeout = timeout_flag_n;
    next_powerdown = powerdown_flag_n;
    next_overflow = stack_overflow_flag;
    next_underflow = stack_underflow_flag;
    next_watchdog = watchdog_reset_flag_n;
    next_pin = pin_reset_flag_n;
    next_instr = instruction_reset_flag_n;
    next_poweron = poweron_flag_n;
    next_brownout = brownout_flag_n;
    next_asleep = ASLEEP;
    next_reset = 1'b0;
    if (wr_status)
    begin
      next_timeout = DAT_I[`RCF_ST_TIMEOUT];
      next_powerdown = DAT_I[`RCF_ST_POWERDOWN];
    end
    if (wr_pwrctl)
    begin
      next_overflow = DAT_I[`RCF_PC_OVERFLOW];
      next_underflow = DAT_I[`RCF_PC_UNDERFLOW];
      next_watchdog = DAT_I[`RCF_PC_WDT];
      next_pin = DAT_I[`RCF_PC_PIN];
      next_instr = DAT_I[`RCF_PC_INSTR];
      next_poweron = DAT_I[`RCF_PC_POWERON];
      next_brownout = DAT_I[`RCF_PC_BROWNOUT];
    end
    if (cmd_wdtclr)
    begin
      next_timeout = 1'b1;
      next_powerdown = 1'b1;
    end
    if (cmd_sleep && !ASLEEP)
    begin
      next_timeout = 1'b1;
      next_powerdown = 1'b0;
      next_asleep = 1'b1;
    end
    if (ASLEEP && WAKE_INTERRUPT)
    begin
      next_timeout = 1'b1;
      next_powerdown = 1'b0;
      next_asleep = 1'b0;
    end
    if (cmd_instr)
    begin
      next_instr = 1'b0;
      next_reset = 1'b1;
    end
    if (ovf_evt)
    begin
      next_overflow = 1'b1;
      next_reset = 1'b1;
    end
    if (unf_evt)
    begin
      next_underflow = 1'b1;
      next_reset = 1'b1;
    end
    if (WATCHDOG_TIMEOUT)
    begin
      if (ASLEEP)
      begin
        next_timeout = 1'b0;
        next_powerdown = 1'b0;
        next_asleep = 1'b0;
      end
      else
      begin
        next_watchdog = 1'b0;
        next_timeout = 1'b0;
        next_reset = 1'b1;
      end
    end
    if (pin_evt)
    begin
      next_pin = 1'b0;
      next_reset = 1'b1;
      if (ASLEEP)
      begin
        next_timeout = 1'b1;
        next_powerdown = 1'b0;
      end
    end
    if (brownout_evt)
    begin
      next_brownout = 1'b0;
      next_timeout = 1'b1;
      next_powerdown = 1'b1;
      next_pin = 1'b1;
      next_instr = 1'b1;
      next_overflow = 1'b0;
      next_underflow = 1'b0;
      next_reset = 1'b1;
    end
    if (next_reset)
      next_asleep = 1'b0;
  end

  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      timeout_flag_n <= status_init[`RCF_ST_TIMEOUT];
      powerdown_flag_n <= status_init[`RCF_ST_POWERDOWN];
      stack_overflow_flag <= pwrctl_init[`RCF_PC_OVERFLOW];
      stack_underflow_flag <= pwrctl_init[`RCF_PC_UNDERFLOW];
      watchdog_reset_flag_n <= pwrctl_init[`RCF_PC_WDT];
      pin_reset_flag_n <= pwrctl_init[`RCF_PC_PIN];
      instruction_reset_flag_n <= pwrctl_init[`RCF_PC_INSTR];
      poweron_flag_n <= pwrctl_init[`RCF_PC_POWERON];
      // undefined after power-on, held at a fixed value
      brownout_flag_n <= pwrctl_init[`RCF_PC_BROWNOUT];
      ASLEEP <= 1'b0;
      CORE_RESET <= 1'b0;
    end
    else
    begin
      timeout_flag_n <= next_timeout;
      powerdown_flag_n <= next_powerdown;
      stack_overflow_flag <= next_overflow;
      stack_underflow_flag <= next_underflow;
      watchdog_reset_flag_n <= next_watchdog;
      pin_reset_flag_n <= next_pin;
      instruction_reset_flag_n <= next_instr;
      poweron_flag_n <= next_poweron;
      brownout_flag_n <= next_brownout;
      ASLEEP <= next_asleep;
      CORE_RESET <= next_reset;
    end
  end

  // ************************************************************
  // wishbone answer
  // ************************************************************
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end
    else
    begin
      ACK_O <= wb_req && !ACK_O;
      if (wb_req && !ACK_O)
      begin
        case (ADR_I)
          `RCF_OFS_STATUS:
            DAT_O <= {30'h00000000, timeout_flag_n, powerdown_flag_n};
          `RCF_OFS_PWRCTL:
            DAT_O <= {24'h000000, pwrctl_rd};
          `RCF_OFS_CTRL:
            DAT_O <= {29'h00000000, ASLEEP, 2'h0};
          `RCF_OFS_STACK:
            DAT_O <= {26'h0000000, fuse_s, stk_depth};
          default:
            DAT_O <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // rcf_top
`default_nettype wire

// ---- dv/rcf_top_chk.sv ----
/*
 * Checker for the reset-cause flag block, bound to rcf_top.
 * Assumes CLK is the only clock and RST the power-on reset.
 */
`timescale 1ns/100ps
`default_nettype none

module rcf_top_chk
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // observed ports
  input wire logic ACK_O,
  input wire logic EXTERNAL_RESET_PIN_N,
  input wire logic BROWNOUT_DETECT,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic WAKE_INTERRUPT,
  input wire logic CORE_RESET,
  input wire logic ASLEEP
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_reset_soon;
    ##[1:4] CORE_RESET;
  endsequence
  sequence s_pin_fall;
    $fell(EXTERNAL_RESET_PIN_N);
  endsequence
  property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
  property p_rst_pulse; CORE_RESET |=> !CORE_RESET; endproperty
  property p_wdt_wake;
    ASLEEP && WATCHDOG_TIMEOUT |=> !ASLEEP && !CORE_RESET;
  endproperty
  property p_wdt_reset; !ASLEEP && WATCHDOG_TIMEOUT |=> CORE_RESET; endproperty
  property p_int_wake;
    ASLEEP && WAKE_INTERRUPT && !WATCHDOG_TIMEOUT |=> !ASLEEP;
  endproperty
  property p_pin_reset; s_pin_fall |-> s_reset_soon; endproperty
  property p_bor_reset; $rose(BROWNOUT_DETECT) |-> s_reset_soon; endproperty
  property p_release; $fell(RST) |-> !ASLEEP && !CORE_RESET; endproperty
  property p_reset_wakes; CORE_RESET |-> ##[0:1] !ASLEEP; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("core reset longer than one cycle");
  a_wdt_wake: assert property (p_wdt_wake)
    else $error("watchdog did not wake without reset");
  a_wdt_reset: assert property (p_wdt_reset)
    else $error("watchdog while awake gave no reset");
  a_int_wake: assert property (p_int_wake)
    else $error("interrupt did not wake");
  a_pin_reset: assert property (p_pin_reset)
    else $error("reset pin gave no core reset");
  a_bor_reset: assert property (p_bor_reset)
    else $error("brown-out gave no core reset");
  a_release: assert property (p_release)
    else $error("outputs wrong after power-on");
  a_reset_wakes: assert property (p_reset_wakes)
    else $error("core reset left device asleep");
endmodule // rcf_top_chk

bind rcf_top rcf_top_chk i_rcf_top_chk (.CLK(CLK), .RST(RST), .ACK_O(ACK_O),
  .EXTERNAL_RESET_PIN_N(EXTERNAL_RESET_PIN_N),
  .BROWNOUT_DETECT(BROWNOUT_DETECT), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
  .WAKE_INTERRUPT(WAKE_INTERRUPT), .CORE_RESET(CORE_RESET), .ASLEEP(ASLEEP));
`default_nettype wire

// ---- dv/rcf_top_tb.sv ----
/*
 * Self-checking bench for rcf_top: drives events and Wishbone reads.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/100ps
`default_nettype none

module rcf_top_tb;
  // ************************************************************
  // signals and design
  // ************************************************************
  logic CLK = 0, RST = 1, CYC_I = 0, STB_I = 0, WE_I = 0;
  logic [3:0] ADR_I = 4'h0, SEL_I = 4'h0;
  logic [31:0] DAT_I = 32'h0;
  logic PIN_N = 1, BROWNOUT = 0, FUSE = 1, WDT = 0;
  logic WAKE = 0, PUSH = 0, POP = 0;
  wire [31:0] DAT_O;
  wire ACK_O, CORE_RESET, ASLEEP;
  integer seed = 32'he759c871, n_mismatch = 0, n_compared = 0, cyc = 0;
  logic [7:0] q[$];
  logic [7:0] st = 8'h03, pc = 8'h1C;
  rcf_top i_rcf_top (.CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
    .ACK_O(ACK_O), .EXTERNAL_RESET_PIN_N(PIN_N), .BROWNOUT_DETECT(BROWNOUT),
    .STACK_ERROR_RESET_FUSE(FUSE), .WATCHDOG_TIMEOUT(WDT),
    .WAKE_INTERRUPT(WAKE), .STACK_PUSH(PUSH), .STACK_POP(POP),
    .CORE_RESET(CORE_RESET), .ASLEEP(ASLEEP));
  initial forever #5 CLK = ~CLK;
  // ************************************************************
  // tasks
  // ************************************************************
  task summarize;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
      n_compared++;
      if (seen !== exp)
      begin
        n_mismatch++;
        $display("Error at %0t: read %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge CLK);
  endtask
  task wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    begin
      @(posedge CLK);
      CYC_I <= 1; STB_I <= 1; WE_I <= we; ADR_I <= a; SEL_I <= 4'hF;
      DAT_I <= {$random(seed)} & 32'hFFFFFF00 | {24'h0, d};
      @(posedge CLK);
      while (ACK_O !== 1'b1) @(posedge CLK);
      CYC_I <= 0; STB_I <= 0;
    end
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    begin
      q.push_back(e);
      wb(0, a, 8'h00);
    end
  endtask
  // ************************************************************
  // monitor and timeout
  // ************************************************************
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (ACK_O === 1'b1 && WE_I === 1'b0 && q.size() > 0)
      chk(DAT_O[7:0], q.pop_front());
    if (cyc == 5000)
    begin
      n_mismatch++;
      summarize;
    end
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    idle(2);
    RST <= 0;
    rd(4'h0, st); rd(4'h4, pc);
    @(posedge CLK) PIN_N <= 0;
    idle(5); PIN_N <= 1; idle(4); pc[3] = 0;
    rd(4'h4, pc); rd(4'h0, st);
    wb(1, 4'h8, 8'h01); idle(4); pc[2] = 0;
    rd(4'h4, pc);
    @(posedge CLK) WDT <= 1;
    @(posedge CLK) WDT <= 0;
    idle(4); pc[4] = 0; st[1] = 0;
    rd(4'h4, pc); rd(4'h0, st);
    wb(1, 4'h0, 8'h00); wb(1, 4'h4, 8'h03); st = 8'h00; pc = 8'h03;
    rd(4'h4, pc); rd(4'h0, st);
    @(posedge CLK) BROWNOUT <= 1;
    idle(5); BROWNOUT <= 0; idle(4); st = 8'h03; pc = pc & 8'h3E | 8'h0C;
    rd(4'h4, pc); rd(4'h0, st);
    $display("pin, watchdog, instruction and brown-out done");
    wb(1, 4'h8, 8'h02); st = 8'h02;
    rd(4'h8, 8'h04); rd(4'h0, st);
    @(posedge CLK) WDT <= 1;
    @(posedge CLK) WDT <= 0;
    idle(3); st = 8'h00;
    rd(4'h0, st); rd(4'h8, 8'h00);
    wb(1, 4'h8, 8'h02); wb(1, 4'h0, 8'h00); st = 8'h02;
    @(posedge CLK) WAKE <= 1;
    @(posedge CLK) WAKE <= 0;
    idle(3);
    rd(4'h0, st); rd(4'h8, 8'h00);
    wb(1, 4'h8, 8'h02); wb(1, 4'h0, 8'h00);
    @(posedge CLK) PIN_N <= 0;
    idle(5); PIN_N <= 1; idle(4); pc[3] = 0;
    rd(4'h4, pc); rd(4'h0, st); rd(4'h8, 8'h00);
    wb(1, 4'h8, 8'h04); st = 8'h03;
    rd(4'h0, st);
    $display("sleep and wake done");
    @(posedge CLK) PUSH <= 1;
    idle(17); PUSH <= 0; idle(5); pc[7] = 1;
    rd(4'h4, pc); rd(4'hC, 8'h20);
    FUSE <= 0; idle(4); POP <= 1;
    @(posedge CLK) POP <= 0;
    @(posedge CLK) PUSH <= 1;
    idle(17); PUSH <= 0; idle(4);
    rd(4'h4, pc); rd(4'hC, 8'h10);
    FUSE <= 1; idle(4); POP <= 1;
    idle(17); POP <= 0; idle(5); pc[6] = 1;
    rd(4'h4, pc); rd(4'hC, 8'h20);
    $display("stack errors done");
    RST <= 1; idle(2); RST <= 0; st = 8'h03; pc = 8'h1C;
    rd(4'h4, pc); rd(4'h0, st); rd(4'hC, 8'h20);
    $display("second power-on reset done");
    idle(3);
    summarize;
  end
endmodule // rcf_top_tb
`default_nettype wire
